// ==== logic/dbm_regs_pkg.sv ====
// shared offsets, field positions and reset values of the bus-master bank
`default_nettype none
package dbm_regs_pkg;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CHAN1_BASE = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_CHAN0_ALT  = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_CHAN1_ALT  = 8'h18;

   localparam int BIT_RUN      = 0;
   localparam int BIT_DIR      = 3;
   localparam int BIT_ACTIVE   = 16;
   localparam int BIT_FAULT    = 17;
   localparam int BIT_DONE     = 18;
   localparam int BIT_EMPTY    = 19;
   localparam int BIT_TIMER    = 20;
   localparam int BIT_CAP_LO   = 21;
   localparam int BIT_CAP_HI   = 22;
   localparam int BIT_SINGLE   = 23;
   localparam int BIT_ANY_TMR  = 15;
   localparam int BIT_C1_IRQ   = 14;
   localparam int SCR_KEEP_HI  = 13;
   localparam int SCR_KEEP_LO  = 12;
   localparam int SCR_PCI_HI   = 11;
   localparam int SCR_PCI_LO   = 10;
   localparam int SCR_PWR_HI   = 9;
   localparam int SCR_PWR_LO   = 8;
   localparam int C1_VIEW_LO   = 24;
   localparam int BASE_LO      = 2;
   localparam int BYTE_LANE0   = 0;
   localparam int BYTE_LANE1   = 1;
   localparam int BYTE_LANE2   = 2;

   localparam logic        SINGLE_CHANNEL_ONLY = 1'b0;
   localparam logic [1:0]  BASE_LOW_BITS       = 2'h0;
   localparam logic [31:0] BASE_RESET          = 32'h0000_0000;
   localparam logic [1:0]  SCR_CLEAR           = 2'h0;
   localparam logic [31:0] WORD_ZERO           = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== logic/dbm_chan_ctrl.sv ====
// control and status flags of one bus-master channel
`default_nettype none
module dbm_chan_ctrl (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_wr,
   input  wire logic [3:0]  i_be,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_chan_irq,
   input  wire logic        i_mem_flushed,
   input  wire logic        i_bus_error,
   input  wire logic        i_xfer_start,
   input  wire logic        i_xfer_complete,
   output logic             o_run,
   output logic             o_dir,
   output logic [1:0]       o_cap,
   output logic             o_done,
   output logic             o_fault,
   output logic             o_active,
   output logic             o_abort
);
   logic       run_r, dir_r, done_r, fault_r, active_r, abort_r;
   logic [1:0] cap_r;
   logic       run_nxt, dir_nxt, done_nxt, fault_nxt, active_nxt;
   logic [1:0] cap_nxt;
   wire  logic wr_lo   = i_wr & i_be[dbm_regs_pkg::BYTE_LANE0];
   wire  logic wr_hi   = i_wr & i_be[dbm_regs_pkg::BYTE_LANE2];
   wire  logic clr_done  = wr_hi & i_wdata[dbm_regs_pkg::BIT_DONE];
   wire  logic clr_fault = wr_hi & i_wdata[dbm_regs_pkg::BIT_FAULT];
   // memory-bound transfers also wait for the last data to land
   wire  logic set_done  = i_chan_irq & (~dir_r | i_mem_flushed);

   assign run_nxt = wr_lo ? i_wdata[dbm_regs_pkg::BIT_RUN] : run_r;
   assign dir_nxt = wr_lo ? i_wdata[dbm_regs_pkg::BIT_DIR] : dir_r;
   // capability bits are storage only; only the register read-back views read them
   assign cap_nxt = wr_hi ? i_wdata[dbm_regs_pkg::BIT_CAP_HI:
                                    dbm_regs_pkg::BIT_CAP_LO] : cap_r;
   // set wins over a clear arriving in the same cycle
   assign done_nxt = run_r ? (set_done | (done_r & ~clr_done))
                           : i_chan_irq;
   assign fault_nxt = (i_bus_error & active_r)
                    | (fault_r & ~clr_fault);
   assign active_nxt = run_r & (i_xfer_start | active_r)
                     & ~i_xfer_complete;

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         run_r    <= 1'b0;
         dir_r    <= 1'b0;
         cap_r    <= 2'h0;
         done_r   <= 1'b0;
         fault_r  <= 1'b0;
         active_r <= 1'b0;
         abort_r  <= 1'b0;
      end else begin
         run_r    <= run_nxt;
         dir_r    <= dir_nxt;
         cap_r    <= cap_nxt;
         done_r   <= done_nxt;
         fault_r  <= fault_nxt;
         active_r <= active_nxt;
         abort_r  <= run_r & ~run_nxt & active_r;
      end
   end

   assign o_run    = run_r;
   assign o_dir    = dir_r;
   assign o_cap    = cap_r;
   assign o_done   = done_r;
   assign o_fault  = fault_r;
   assign o_active = active_r;
   assign o_abort  = abort_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_stop_busy;
      o_run && o_active && wr_lo && !i_wdata[dbm_regs_pkg::BIT_RUN];
   endsequence
   sequence s_abort_once;
      o_abort ##1 !o_abort;
   endsequence

   a_abort_on_stop: assert property (s_stop_busy |=> s_abort_once)
      else $error("stop during transfer did not pulse abort once");
   a_active_drops: assert property (!o_run |=> !o_active)
      else $error("active flag survived a stopped channel");
   a_fault_sets: assert property (i_bus_error && o_active |=> o_fault)
      else $error("bus error did not set fault flag");
   a_fault_holds: assert property (o_fault && !clr_fault |=> o_fault)
      else $error("fault flag lost without a one written");
   a_done_follows: assert property (!o_run |=> o_done == $past(i_chan_irq))
      else $error("done flag does not follow irq while idle");
   a_done_sticky: assert property (o_run && o_done && !clr_done |=> o_done)
      else $error("done flag dropped while running");
   a_done_waits: assert property (o_run && !o_done && o_dir && i_chan_irq
      && !i_mem_flushed |=> !o_done)
      else $error("done set before memory flushed");
   a_done_to_drive: assert property (o_run && !o_dir && i_chan_irq
      |=> o_done)
      else $error("done not set on irq for drive-bound transfer");
endmodule // dbm_chan_ctrl
`default_nettype wire

// ==== logic/dbm_regs.sv ====
// register bank: channel 1 descriptor base and second bus-master registers
`default_nettype none
module dbm_regs (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [3:0]  i_reg_be,
   input  wire logic [31:0] i_reg_wdata,
   output logic [31:0]      o_reg_rdata,
   output logic             o_reg_rvalid,
   input  wire logic        i_first_set_access0,
   input  wire logic        i_first_set_access1,
   input  wire logic        i_d3_entry,
   input  wire logic        i_chan0_irq,
   input  wire logic        i_chan1_irq,
   input  wire logic        i_chan0_mem_flushed,
   input  wire logic        i_chan1_mem_flushed,
   input  wire logic        i_chan0_bus_error,
   input  wire logic        i_chan1_bus_error,
   input  wire logic        i_chan0_xfer_start,
   input  wire logic        i_chan1_xfer_start,
   input  wire logic        i_chan0_xfer_complete,
   input  wire logic        i_chan1_xfer_complete,
   input  wire logic        i_chan0_timer_expired,
   input  wire logic        i_chan1_timer_expired,
   input  wire logic        i_chan0_fifo_empty,
   input  wire logic        i_chan1_fifo_empty,
   output logic [31:0]      o_descriptor_list_base1,
   output logic             o_chan0_master_run,
   output logic             o_chan1_master_run,
   output logic             o_chan0_transfer_direction,
   output logic             o_chan1_transfer_direction,
   output logic             o_chan0_abort,
   output logic             o_chan1_abort,
   output logic             o_chan0_taskfile_abort,
   output logic             o_chan1_taskfile_abort,
   output logic             o_chan0_large_block,
   output logic             o_chan1_large_block
);
   logic [31:0] base_r;
   logic [1:0]  scr_keep_r, scr_pci_r, scr_pwr_r;
   logic [31:0] rdata_r;
   logic        rvalid_r, large0_r, large1_r;
   logic [31:0] rdata_nxt;
   logic [1:0]  cap0, cap1;
   logic        done0, done1, fault0, fault1, active0, active1;
   logic        abort0, abort1;

   wire logic sel_base = i_reg_addr == dbm_regs_pkg::OFS_CHAN1_BASE;
   wire logic sel_alt0 = i_reg_addr == dbm_regs_pkg::OFS_CHAN0_ALT;
   wire logic sel_alt1 = i_reg_addr == dbm_regs_pkg::OFS_CHAN1_ALT;
   wire logic wr_base  = i_reg_wr & sel_base;
   wire logic wr_alt0  = i_reg_wr & sel_alt0;
   wire logic wr_alt1  = i_reg_wr & sel_alt1;
   wire logic wr_scr   = wr_alt0 & i_reg_be[dbm_regs_pkg::BYTE_LANE1];
   wire logic any_timer = i_chan0_timer_expired
                        | i_chan1_timer_expired;

   // common 24-bit view of one channel: bits 23..16 status, 3 dir, 0 run
   function automatic logic [23:0] chan_view(
      input logic [1:0] cap, input logic tmr, input logic empty,
      input logic done, input logic fault, input logic act,
      input logic dir, input logic run);
      logic [23:0] v;
      v = 24'h00_0000;
      v[dbm_regs_pkg::BIT_SINGLE] = dbm_regs_pkg::SINGLE_CHANNEL_ONLY;
      v[dbm_regs_pkg::BIT_CAP_HI:dbm_regs_pkg::BIT_CAP_LO] = cap;
      v[dbm_regs_pkg::BIT_TIMER]  = tmr;
      v[dbm_regs_pkg::BIT_EMPTY]  = empty;
      v[dbm_regs_pkg::BIT_DONE]   = done;
      v[dbm_regs_pkg::BIT_FAULT]  = fault;
      v[dbm_regs_pkg::BIT_ACTIVE] = act;
      v[dbm_regs_pkg::BIT_DIR]    = dir;
      v[dbm_regs_pkg::BIT_RUN]    = run;
      return v; // reserved positions stay zero
   endfunction

   dbm_chan_ctrl u_chan0 (
      .i_clk           (i_clk),
      .i_reset_n       (i_reset_n),
      .i_wr            (wr_alt0),
      .i_be            (i_reg_be),
      .i_wdata         (i_reg_wdata),
      .i_chan_irq      (i_chan0_irq),
      .i_mem_flushed   (i_chan0_mem_flushed),
      .i_bus_error     (i_chan0_bus_error),
      .i_xfer_start    (i_chan0_xfer_start),
      .i_xfer_complete (i_chan0_xfer_complete),
      .o_run           (o_chan0_master_run),
      .o_dir           (o_chan0_transfer_direction),
      .o_cap           (cap0),
      .o_done          (done0),
      .o_fault         (fault0),
      .o_active        (active0),
      .o_abort         (abort0)
   );

   // channel 1 control is writable only at its own second address
   dbm_chan_ctrl u_chan1 (
      .i_clk           (i_clk),
      .i_reset_n       (i_reset_n),
      .i_wr            (wr_alt1),
      .i_be            (i_reg_be),
      .i_wdata         (i_reg_wdata),
      .i_chan_irq      (i_chan1_irq),
      .i_mem_flushed   (i_chan1_mem_flushed),
      .i_bus_error     (i_chan1_bus_error),
      .i_xfer_start    (i_chan1_xfer_start),
      .i_xfer_complete (i_chan1_xfer_complete),
      .o_run           (o_chan1_master_run),
      .o_dir           (o_chan1_transfer_direction),
      .o_cap           (cap1),
      .o_done          (done1),
      .o_fault         (fault1),
      .o_active        (active1),
      .o_abort         (abort1)
   );

   wire logic [23:0] view0 = chan_view(cap0, i_chan0_timer_expired,
      i_chan0_fifo_empty, done0, fault0, active0,
      o_chan0_transfer_direction, o_chan0_master_run);
   wire logic [23:0] view1 = chan_view(cap1, i_chan1_timer_expired,
      i_chan1_fifo_empty, done1, fault1, active1,
      o_chan1_transfer_direction, o_chan1_master_run);

   // upper byte of channel 0 view is channel 1 bits 23..16
   wire logic [31:0] word_alt0 = {view1[23:16], view0[23:16],
      any_timer, done1, scr_keep_r, scr_pci_r, scr_pwr_r,
      view0[7:0]};
   wire logic [31:0] word_alt1 = {8'h00, view1};
   wire logic [31:0] word_base = {base_r[31:dbm_regs_pkg::BASE_LO],
      dbm_regs_pkg::BASE_LOW_BITS};

   // unmapped offsets read as zero
   assign rdata_nxt = sel_base ? word_base
                    : sel_alt0 ? word_alt0
                    : sel_alt1 ? word_alt1
                    : dbm_regs_pkg::WORD_ZERO;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_base_lane
         always_ff @(posedge i_clk) begin
            if (!i_reset_n) begin
               base_r[8*g +: 8] <= dbm_regs_pkg::BASE_RESET[8*g +: 8];
            end else if (wr_base && i_reg_be[g]) begin
               base_r[8*g +: 8] <= i_reg_wdata[8*g +: 8];
            end
         end
      end
   endgenerate

   // no reset reaches these: contents are whatever software left
   always_ff @(posedge i_clk) begin
      if (wr_scr) begin
         scr_keep_r <= i_reg_wdata[dbm_regs_pkg::SCR_KEEP_HI:
                                   dbm_regs_pkg::SCR_KEEP_LO];
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         scr_pci_r <= dbm_regs_pkg::SCR_CLEAR;
      end else if (wr_scr) begin
         scr_pci_r <= i_reg_wdata[dbm_regs_pkg::SCR_PCI_HI:
                                  dbm_regs_pkg::SCR_PCI_LO];
      end
   end

   // bus reset deliberately does not touch this pair
   always_ff @(posedge i_clk) begin
      if (i_d3_entry) begin
         scr_pwr_r <= dbm_regs_pkg::SCR_CLEAR;
      end else if (wr_scr) begin
         scr_pwr_r <= i_reg_wdata[dbm_regs_pkg::SCR_PWR_HI:
                                  dbm_regs_pkg::SCR_PWR_LO];
      end
   end

   // a first-set access drops back to generic mode
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         large0_r <= 1'b0;
         large1_r <= 1'b0;
      end else begin
         large0_r <= (i_reg_wr | i_reg_rd) & sel_alt0 ? 1'b1
                   : i_first_set_access0 ? 1'b0 : large0_r;
         large1_r <= (i_reg_wr | i_reg_rd) & sel_alt1 ? 1'b1
                   : i_first_set_access1 ? 1'b0 : large1_r;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rdata_r  <= dbm_regs_pkg::WORD_ZERO;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= i_reg_rd ? rdata_nxt : rdata_r;
         rvalid_r <= i_reg_rd;
      end
   end

   assign o_reg_rdata             = rdata_r;
   assign o_reg_rvalid            = rvalid_r;
   assign o_descriptor_list_base1 = word_base;
   assign o_chan0_abort           = abort0;
   assign o_chan1_abort           = abort1;
   assign o_chan0_taskfile_abort  = o_chan0_master_run;
   assign o_chan1_taskfile_abort  = o_chan1_master_run;
   assign o_chan0_large_block     = large0_r;
   assign o_chan1_large_block     = large1_r;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_base_low_zero: assert property (i_reg_rd && sel_base
      |=> o_reg_rvalid && o_reg_rdata[1:0] == 2'h0)
      else $error("descriptor base low bits not zero");
   a_mirror_view: assert property (i_reg_rd && sel_alt0
      |=> o_reg_rdata[26:24] == $past(view1[18:16])
       && o_reg_rdata[31:29] == $past(view1[23:21]))
      else $error("channel 1 mirror in channel 0 view wrong");
   a_single_zero: assert property (i_reg_rd && (sel_alt0 || sel_alt1)
      |=> !o_reg_rdata[23])
      else $error("single-channel bit read one");
   a_irq_mirror: assert property (i_reg_rd && sel_alt0
      |=> o_reg_rdata[14] == $past(done1)
       && o_reg_rdata[15] == $past(any_timer))
      else $error("channel 1 done or timer summary wrong");
   a_tf_abort: assert property (wr_alt0 && i_reg_be[0] && i_reg_wdata[0]
      |=> o_chan0_taskfile_abort)
      else $error("running channel 0 not guarding task file");
   a_scr_pci: assert property ($rose(i_reset_n) |-> scr_pci_r == 2'h0)
      else $error("bus reset did not clear scratch pair");
endmodule // dbm_regs
`default_nettype wire

// ==== bench/dbm_eng_model.sv ====
// behavioural model of the channel 0 transfer engine beside the bank
`default_nettype none
module dbm_eng_model (
   input  wire logic i_clk,
   input  wire logic i_run,
   input  wire logic i_irq_req,
   input  wire logic i_flush_req,
   input  wire logic i_err_req,
   input  wire logic i_fin_req,
   output logic      o_irq,
   output logic      o_flushed,
   output logic      o_xfer_start,
   output logic      o_bus_error,
   output logic      o_xfer_complete
);
   timeunit 1ns;
   timeprecision 1ps;
   logic run_d;
   initial begin
      {run_d, o_irq, o_flushed, o_xfer_start, o_bus_error} = '0;
      o_xfer_complete = 1'b0;
   end
   always @(posedge i_clk) begin
      run_d           <= i_run;
      // engine only starts moving data on a fresh run
      o_xfer_start    <= i_run & ~run_d;
      o_irq           <= i_irq_req;
      // flush is reported with the irq, never ahead of it
      o_flushed       <= i_flush_req & i_irq_req;
      o_bus_error     <= i_err_req;
      o_xfer_complete <= i_fin_req;
   end
endmodule // dbm_eng_model
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench of the bus-master register bank
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0]  a;
      logic [3:0]  b;
      logic [31:0] d;
      logic [31:0] e;
   } dbm_row_t;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [3:0]  be = 4'h0;
   logic [31:0] wdata = 32'h0000_0000, rdata, base1, d;
   logic        fsa0 = 1'b0, fsa1 = 1'b0, d3 = 1'b0, saw_ab = 1'b0;
   logic        irq1 = 1'b0, fl1 = 1'b0, er1 = 1'b0, st1 = 1'b0;
   logic        fin1 = 1'b0, tmr0 = 1'b0, tmr1 = 1'b0;
   logic        emp0 = 1'b1, emp1 = 1'b1;
   logic        irq_q = 1'b0, fl_q = 1'b0, err_q = 1'b0, fin_q = 1'b0;
   logic        irq0, fl0, st0, er0, fin0, rvalid;
   logic        run0, run1, dir0, dir1, ab0, ab1, tfa0, tfa1, lb0, lb1;
   int          mismatches = 0, n_checks = 0;
   dbm_row_t    rows [5] = '{
      '{8'h0c, 4'hf, 32'hffff_ffff, 32'hffff_fffc},
      '{8'h0c, 4'h1, 32'h1234_5678, 32'hffff_ff78},
      '{8'h14, 4'hf, 32'hffff_ffff, 32'h0000_0000},
      '{8'h18, 4'hf, 32'hffff_fff6, 32'h0068_0000},
      '{8'h10, 4'h3, 32'h0000_3f08, 32'h6808_3f08}};

   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (ab0 === 1'b1) begin
         saw_ab <= 1'b1;
      end
   end

   dbm_eng_model dbm_eng_model_i (.i_clk(clk), .i_run(run0),
      .i_irq_req(irq_q), .i_flush_req(fl_q), .i_err_req(err_q),
      .i_fin_req(fin_q), .o_irq(irq0), .o_flushed(fl0),
      .o_xfer_start(st0), .o_bus_error(er0), .o_xfer_complete(fin0));

   dbm_regs dbm_regs_i (.i_clk(clk), .i_reset_n(rst_n), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_be(be),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_first_set_access0(fsa0), .i_first_set_access1(fsa1),
      .i_d3_entry(d3), .i_chan0_irq(irq0), .i_chan1_irq(irq1),
      .i_chan0_mem_flushed(fl0), .i_chan1_mem_flushed(fl1),
      .i_chan0_bus_error(er0), .i_chan1_bus_error(er1),
      .i_chan0_xfer_start(st0), .i_chan1_xfer_start(st1),
      .i_chan0_xfer_complete(fin0), .i_chan1_xfer_complete(fin1),
      .i_chan0_timer_expired(tmr0), .i_chan1_timer_expired(tmr1),
      .i_chan0_fifo_empty(emp0), .i_chan1_fifo_empty(emp1),
      .o_descriptor_list_base1(base1), .o_chan0_master_run(run0),
      .o_chan1_master_run(run1), .o_chan0_transfer_direction(dir0),
      .o_chan1_transfer_direction(dir1), .o_chan0_abort(ab0),
      .o_chan1_abort(ab1), .o_chan0_taskfile_abort(tfa0),
      .o_chan1_taskfile_abort(tfa1), .o_chan0_large_block(lb0),
      .o_chan1_large_block(lb1));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [3:0] b,
                         input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      be <= b;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({31'h0000_0000, rvalid}, 32'h0000_0001);
      v = rdata;
   endtask
   // one-cycle request to the engine model
   task automatic pulse_err();
      @(posedge clk);
      err_q <= 1'b1;
      @(posedge clk);
      err_q <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #20000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         wr_reg(rows[i].a, rows[i].b, rows[i].d);
         rd_reg(rows[i].a, d);
         chk(d, rows[i].e);
      end
      chk(base1, 32'hffff_ff78);
      $display("register rows done");
      @(posedge clk);
      tmr1 <= 1'b1;
      emp0 <= 1'b0;
      irq1 <= 1'b1;
      rd_reg(8'h10, d);
      chk(d, 32'h7c00_ff08);
      rd_reg(8'h18, d);
      chk(d, 32'h007c_0000);
      irq1 <= 1'b0;
      tmr1 <= 1'b0;
      $display("status mirrors done");
      wr_reg(8'h10, 4'h1, 32'h0000_0009);
      repeat (3) @(posedge clk);
      #1;
      chk({29'h0000_0000, run0, tfa0, dir0}, 32'h0000_0007);
      rd_reg(8'h10, d);
      chk(d & 32'h0007_0000, 32'h0001_0000);
      pulse_err();
      rd_reg(8'h10, d);
      chk(d & 32'h0007_0000, 32'h0003_0000);
      wr_reg(8'h10, 4'h1, 32'h0000_0000);
      rd_reg(8'h10, d);
      chk(d & 32'h0005_0001, 32'h0000_0000);
      chk({31'h0000_0000, saw_ab}, 32'h0000_0001);
      $display("run and abort done");
      wr_reg(8'h10, 4'h1, 32'h0000_0009);
      irq_q <= 1'b1;
      rd_reg(8'h10, d);
      chk(d & 32'h0004_0000, 32'h0000_0000);
      fl_q <= 1'b1;
      // flushed reaches the flag two edges later; let one pass first
      @(posedge clk);
      rd_reg(8'h10, d);
      chk(d & 32'h0004_0000, 32'h0004_0000);
      irq_q <= 1'b0;
      fl_q <= 1'b0;
      fin_q <= 1'b1;
      @(posedge clk);
      fin_q <= 1'b0;
      rd_reg(8'h10, d);
      chk(d & 32'h0005_0000, 32'h0004_0000);
      wr_reg(8'h10, 4'h4, 32'h0000_0000);
      rd_reg(8'h10, d);
      chk(d & 32'h0004_0000, 32'h0004_0000);
      wr_reg(8'h10, 4'h4, 32'h0006_0000);
      rd_reg(8'h10, d);
      chk(d & 32'h0006_0000, 32'h0000_0000);
      $display("completion flags done");
      // a second reset in mid-run, with the run bit still set
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk({31'h0000_0000, lb0}, 32'h0000_0000);
      rd_reg(8'h10, d);
      chk(d & 32'h0000_3f0f, 32'h0000_3300);
      chk({31'h0000_0000, lb0}, 32'h0000_0001);
      @(posedge clk);
      d3 <= 1'b1;
      @(posedge clk);
      d3 <= 1'b0;
      rd_reg(8'h10, d);
      chk(d & 32'h0000_3f00, 32'h0000_3000);
      @(posedge clk);
      fsa0 <= 1'b1;
      @(posedge clk);
      fsa0 <= 1'b0;
      @(posedge clk);
      #1;
      chk({31'h0000_0000, lb0}, 32'h0000_0000);
      wr_reg(8'h18, 4'h1, 32'h0000_0009);
      @(posedge clk);
      #1;
      chk({28'h000_0000, lb1, run1, dir1, tfa1}, 32'h0000_000f);
      wr_reg(8'h18, 4'h1, 32'h0000_0000);
      @(posedge clk);
      #1;
      chk({29'h0000_0000, run1, tfa1, ab1}, 32'h0000_0000);
      $display("reset and scratch done");
      test_done();
   end
endmodule // tb_top
`default_nettype wire
